// ---- mmdt_cfg_clamp.sv ----
// Forces one channel's settings into their legal ranges.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
module mmdt_cfg_clamp
    import mmdt_pkg::*;
(
    // Raw settings
    input wire mmdt_cfg_t i_cfg,
    // Legal settings
    output mmdt_cfg_t o_cfg
);
    function automatic logic [12:0] clamp_dly(input logic [12:0] d);
        clamp_dly = (d < DLY_MIN) ? DLY_MIN : ((d > DLY_MAX) ? DLY_MAX : d);
    endfunction

    function automatic logic signed [15:0] clamp_val(input logic signed [15:0] v);
        clamp_val = (v < VAL_MIN) ? VAL_MIN : ((v > VAL_MAX) ? VAL_MAX : v);
    endfunction

    // Unused mode codes fall back to the reset mode rather than a dead state
    wire mode_ok = (i_cfg.mode <= MMDT_REPEAT_CYCLE);

    assign o_cfg.mode = mode_ok ? i_cfg.mode : MODE_RST;
    assign o_cfg.first_delay_time = clamp_dly(i_cfg.first_delay_time);
    assign o_cfg.second_delay_time = clamp_dly(i_cfg.second_delay_time);
    assign o_cfg.switch_on_value = clamp_val(i_cfg.switch_on_value);
    assign o_cfg.switch_off_value = clamp_val(i_cfg.switch_off_value);
endmodule // mmdt_cfg_clamp

// ---- mmdt_link_src.sv ----
// Model of the drive logic that feeds the timer bank through internal links.
// Assumes the bench calls its tasks; everything changes on the falling edge.
`timescale 1ns/1ps
module mmdt_link_src
    import mmdt_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Towards the timer bank
    output logic [5:0] o_cfg_we,
    output mmdt_cfg_t o_cfg [NUM_TIMERS],
    output logic [5:0] o_timer_input
);
    initial begin
        o_cfg_we = 6'h00;
        o_timer_input = 6'h00;
        for (int g = 0; g < NUM_TIMERS; g++) begin
            o_cfg[g] = '0;
        end
    end

    task automatic load(input int ch, input mmdt_cfg_t c);
        @(negedge i_clk);
        o_cfg_we[ch] = 1'b1;
        o_cfg[ch] = c;
        @(negedge i_clk);
        o_cfg_we[ch] = 1'b0;
        // Settings mean nothing without the strobe, so show no stale copy
        o_cfg[ch] = ~c;
    endtask

    task automatic set_in(input int ch, input logic v);
        @(negedge i_clk);
        o_timer_input[ch] = v;
    endtask
endmodule // mmdt_link_src

// ---- mmdt_pkg.sv ----
// Shared types and constants for the six-channel delay timer bank.
// Assumes one 100 MHz clock and settings written by same-clock drive logic.
package mmdt_pkg;

    // Clock and tick timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_TIME_MS = 100;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
    localparam int unsigned TICK_CNT_W = 24;

    // Bank layout
    localparam int unsigned NUM_TIMERS = 6;
    localparam int unsigned NUM_MODES = 6;

    // Delay times in tenths of a second, values in hundredths of a percent
    localparam int unsigned DLY_W = 13;
    localparam int unsigned VAL_W = 16;
    localparam logic [12:0] DLY_MIN = 13'h0001;
    localparam logic [12:0] DLY_MAX = 13'h1770;
    localparam logic [12:0] DLY1_RST = 13'h0032;
    localparam logic [12:0] DLY2_RST = 13'h0032;
    localparam logic signed [15:0] VAL_MIN = -16'sh7530;
    localparam logic signed [15:0] VAL_MAX = 16'sh7530;
    localparam logic signed [15:0] ON_VAL_RST = 16'sh2710;
    localparam logic signed [15:0] OFF_VAL_RST = 16'sh0000;

    typedef enum logic [2:0] {
        MMDT_ON_DELAY = 3'b000,
        MMDT_OFF_DELAY = 3'b001,
        MMDT_ONE_SHOT = 3'b010,
        MMDT_ONE_SHOT_RETRIG = 3'b011,
        MMDT_SINGLE_CYCLE = 3'b100,
        MMDT_REPEAT_CYCLE = 3'b101
    } mmdt_mode_t;

    localparam mmdt_mode_t MODE_RST = MMDT_ON_DELAY;

    typedef enum logic [1:0] {
        MMDT_ST_IDLE = 2'b00,
        MMDT_ST_PHASE1 = 2'b01,
        MMDT_ST_PHASE2 = 2'b10
    } mmdt_state_t;

    typedef struct packed {
        mmdt_mode_t mode;
        logic [12:0] first_delay_time;
        logic [12:0] second_delay_time;
        logic signed [15:0] switch_on_value;
        logic signed [15:0] switch_off_value;
    } mmdt_cfg_t;

    typedef struct packed {
        logic timer_run_status;
        logic [12:0] elapsed_time_value;
        logic switch_state;
        logic signed [15:0] timer_result;
    } mmdt_stat_t;

endpackage

// ---- mmdt_tick_gen.sv ----
// Prescaler producing the 0.1 s timing tick as a one-cycle enable.
// Assumes the system clock; the period in cycles is a parameter.
`timescale 1ns/1ps
module mmdt_tick_gen
    import mmdt_pkg::*;
#(
    parameter logic [23:0] PERIOD = 24'(TICK_CYCLES)
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Tick out
    output logic o_tick
);
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic tick_d;
    logic tick_q;

    assign tick_d = (cnt_q == PERIOD - 24'h000001);
    assign cnt_d = tick_d ? 24'h000000 : cnt_q + 24'h000001;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_q <= 24'h000000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;
endmodule // mmdt_tick_gen

// ---- mmdt_timer_bank.sv ----
// Bank of six multi-mode delay timers driving internal switches.
// Inputs and settings come from same-clock drive logic; no synchronisers.
`timescale 1ns/1ps
module mmdt_timer_bank
    import mmdt_pkg::*;
#(
    parameter logic [23:0] TICK_PERIOD = 24'(TICK_CYCLES)
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Settings, one load strobe per channel
    input wire logic [5:0] i_cfg_we,
    input wire mmdt_cfg_t i_cfg [NUM_TIMERS],
    // Timer inputs from internal links
    input wire logic [5:0] i_timer_input,
    // Settings in force
    output mmdt_cfg_t o_cfg [NUM_TIMERS],
    // Channel status and results
    output mmdt_stat_t o_stat [NUM_TIMERS]
);
    logic tick;

    mmdt_tick_gen #(
        .PERIOD(TICK_PERIOD)
    ) mmdt_tick_gen_i (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .o_tick(tick)
    );

    // Interval in progress; the counter, the status and the sequencer all ask it
    function automatic logic busy(input mmdt_state_t s);
        busy = (s != MMDT_ST_IDLE);
    endfunction

    // Edge towards lvl, judged against the sample of the previous clock
    function automatic logic edge_to(input logic cur, input logic prv, input logic lvl);
        edge_to = (cur == lvl) && (prv != lvl);
    endfunction

    // Only the second phase of the two cycle modes runs on the second delay
    function automatic logic [12:0] phase_delay(input mmdt_cfg_t c, input mmdt_state_t s);
        if (s == MMDT_ST_PHASE2) begin
            phase_delay = c.second_delay_time;
        end else begin
            phase_delay = c.first_delay_time;
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_ch
            mmdt_cfg_t cfg_clamped;
            mmdt_cfg_t cfg_q;
            mmdt_cfg_t cfg_d;
            logic cfg_load;

            mmdt_state_t state_q;
            mmdt_state_t state_d;
            logic [12:0] cnt_q;
            logic [12:0] cnt_d;
            logic sw_q;
            logic sw_d;
            logic run_q;
            logic run_d;
            logic signed [15:0] result_q;
            logic signed [15:0] result_d;

            logic in_now;
            logic in_prev_q;
            logic rise;
            logic fall;
            logic change;

            logic mode_chg;
            logic idle_now;
            logic cnt_step;
            logic [12:0] dly_cur;
            logic expire;

            mmdt_cfg_clamp mmdt_cfg_clamp_i (
                .i_cfg(i_cfg[g]),
                .o_cfg(cfg_clamped)
            );

            assign cfg_load = i_cfg_we[g];
            assign cfg_d = cfg_load ? cfg_clamped : cfg_q;
            // A mode change abandons any interval so no state leaks across modes
            assign mode_chg = cfg_load && (cfg_clamped.mode != cfg_q.mode);

            assign in_now = i_timer_input[g];
            assign rise = edge_to(in_now, in_prev_q, 1'b1);
            assign fall = edge_to(in_now, in_prev_q, 1'b0);
            assign change = rise || fall;

            assign idle_now = !busy(state_q);
            assign cnt_step = tick && !idle_now;
            assign dly_cur = phase_delay(cfg_q, state_q);
            assign expire = tick && (cnt_q >= dly_cur - 13'h0001);

            assign run_d = busy(state_d);
            // Follows the new switch state and the new settings in the same edge
            assign result_d = sw_d ? cfg_d.switch_on_value : cfg_d.switch_off_value;

            always_comb begin
                state_d = state_q;
                sw_d = sw_q;
                cnt_d = cnt_step ? cnt_q + 13'h0001 : cnt_q;
                if (mode_chg) begin
                    state_d = MMDT_ST_IDLE;
                    sw_d = 1'b0;
                    cnt_d = 13'h0000;
                end else begin
                    case (cfg_q.mode)
                        MMDT_ON_DELAY: begin
                            if (fall) begin
                                state_d = MMDT_ST_IDLE;
                                sw_d = 1'b0;
                            end else if (rise) begin
                                state_d = MMDT_ST_PHASE1;
                                cnt_d = 13'h0000;
                            end else if (state_q == MMDT_ST_PHASE1 && expire) begin
                                state_d = MMDT_ST_IDLE;
                                sw_d = 1'b1;
                            end
                        end
                        MMDT_OFF_DELAY: begin
                            if (rise) begin
                                state_d = MMDT_ST_IDLE;
                                sw_d = 1'b1;
                            end else if (fall) begin
                                state_d = MMDT_ST_PHASE1;
                                cnt_d = 13'h0000;
                            end else if (state_q == MMDT_ST_PHASE1 && expire) begin
                                state_d = MMDT_ST_IDLE;
                                sw_d = 1'b0;
                            end
                        end
                        MMDT_ONE_SHOT: begin
                            if (state_q == MMDT_ST_IDLE) begin
                                if (rise) begin
                                    state_d = MMDT_ST_PHASE1;
                                    sw_d = 1'b1;
                                    cnt_d = 13'h0000;
                                end
                            end else if (expire) begin
                                // Input edges are not looked at here
                                state_d = MMDT_ST_IDLE;
                                sw_d = 1'b0;
                            end
                        end
                        MMDT_ONE_SHOT_RETRIG: begin
                            if (state_q == MMDT_ST_IDLE) begin
                                if (rise) begin
                                    state_d = MMDT_ST_PHASE1;
                                    sw_d = 1'b1;
                                    cnt_d = 13'h0000;
                                end
                            end else if (change) begin
                                cnt_d = 13'h0000;
                            end else if (expire) begin
                                state_d = MMDT_ST_IDLE;
                                sw_d = 1'b0;
                            end
                        end
                        MMDT_SINGLE_CYCLE: begin
                            if (state_q == MMDT_ST_IDLE) begin
                                if (rise) begin
                                    state_d = MMDT_ST_PHASE1;
                                    sw_d = 1'b0;
                                    cnt_d = 13'h0000;
                                end
                            end else if (expire) begin
                                if (state_q == MMDT_ST_PHASE1) begin
                                    state_d = MMDT_ST_PHASE2;
                                    sw_d = 1'b1;
                                    cnt_d = 13'h0000;
                                end else begin
                                    state_d = MMDT_ST_IDLE;
                                    sw_d = 1'b0;
                                end
                            end
                        end
                        MMDT_REPEAT_CYCLE: begin
                            if (!in_now) begin
                                state_d = MMDT_ST_IDLE;
                                sw_d = 1'b0;
                                cnt_d = 13'h0000;
                            end else if (rise || idle_now) begin
                                state_d = MMDT_ST_PHASE1;
                                sw_d = 1'b1;
                                cnt_d = 13'h0000;
                            end else if (expire) begin
                                cnt_d = 13'h0000;
                                if (state_q == MMDT_ST_PHASE1) begin
                                    state_d = MMDT_ST_PHASE2;
                                    sw_d = 1'b0;
                                end else begin
                                    state_d = MMDT_ST_PHASE1;
                                    sw_d = 1'b1;
                                end
                            end
                        end
                        default: begin
                            state_d = MMDT_ST_IDLE;
                            sw_d = 1'b0;
                            cnt_d = 13'h0000;
                        end
                    endcase
                end
            end

            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    cfg_q.mode <= MODE_RST;
                    cfg_q.first_delay_time <= DLY1_RST;
                    cfg_q.second_delay_time <= DLY2_RST;
                    cfg_q.switch_on_value <= ON_VAL_RST;
                    cfg_q.switch_off_value <= OFF_VAL_RST;
                end else begin
                    cfg_q <= cfg_d;
                end
            end

            // Sequencer state and interval count
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    state_q <= MMDT_ST_IDLE;
                end else begin
                    state_q <= state_d;
                end
            end

            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    cnt_q <= 13'h0000;
                end else begin
                    cnt_q <= cnt_d;
                end
            end

            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    sw_q <= 1'b0;
                end else begin
                    sw_q <= sw_d;
                end
            end

            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    run_q <= 1'b0;
                end else begin
                    run_q <= run_d;
                end
            end

            // Edge history starts low, so an input already high counts as a rise
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    in_prev_q <= 1'b0;
                end else begin
                    in_prev_q <= in_now;
                end
            end

            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    result_q <= OFF_VAL_RST;
                end else begin
                    result_q <= result_d;
                end
            end

            assign o_cfg[g] = cfg_q;
            assign o_stat[g].timer_run_status = run_q;
            assign o_stat[g].elapsed_time_value = cnt_q;
            assign o_stat[g].switch_state = sw_q;
            assign o_stat[g].timer_result = result_q;
        end
    endgenerate
endmodule // mmdt_timer_bank

// ---- mmdt_timer_bank_sva.sv ----
// Port-level checker for the timer bank, bound into every instance of it.
// Assumes the bench gives channels 0,1,2,5 the on/off delay, one shot, repeat modes.
`timescale 1ns/1ps
module mmdt_timer_bank_sva
    import mmdt_pkg::*;
#(
    parameter logic [23:0] TICK_PERIOD = 24'(TICK_CYCLES)
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Inputs of the bank
    input wire logic [5:0] i_cfg_we,
    input wire mmdt_cfg_t i_cfg [NUM_TIMERS],
    input wire logic [5:0] i_timer_input,
    // Outputs of the bank
    input wire mmdt_cfg_t o_cfg [NUM_TIMERS],
    input wire mmdt_stat_t o_stat [NUM_TIMERS]
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_reset_state: assert property (disable iff (1'b0) !i_rst_n |=>
        !o_stat[0].switch_state && !o_stat[0].timer_run_status && o_cfg[0].mode == MODE_RST)
        else $error("timer not stopped with switch off after reset");
    a_result_select: assert property (o_stat[1].timer_result == (o_stat[1].switch_state ?
        o_cfg[1].switch_on_value : o_cfg[1].switch_off_value))
        else $error("result does not follow the switch");
    a_ondly_fall: assert property (o_cfg[0].mode == MMDT_ON_DELAY && !i_cfg_we[0] &&
        $fell(i_timer_input[0]) |=> !o_stat[0].switch_state)
        else $error("on delay switch not off at once");
    a_ondly_wait: assert property (o_cfg[0].mode == MMDT_ON_DELAY && !i_cfg_we[0] &&
        o_cfg[0].first_delay_time > 13'h0001 && !o_stat[0].switch_state &&
        $rose(i_timer_input[0]) |=> !o_stat[0].switch_state [*4])
        else $error("on delay switch came on too early");
    a_offdly_rise: assert property (o_cfg[1].mode == MMDT_OFF_DELAY && !i_cfg_we[1] &&
        $rose(i_timer_input[1]) |=> o_stat[1].switch_state && !o_stat[1].timer_run_status)
        else $error("off delay switch not on at once");
    a_oneshot_start: assert property (o_cfg[2].mode == MMDT_ONE_SHOT && !i_cfg_we[2] &&
        !o_stat[2].timer_run_status && $rose(i_timer_input[2])
        |=> o_stat[2].switch_state && o_stat[2].timer_run_status)
        else $error("one shot did not start");
    a_repeat_stop: assert property (o_cfg[5].mode == MMDT_REPEAT_CYCLE && !i_cfg_we[5] &&
        $fell(i_timer_input[5]) |=> !o_stat[5].switch_state && !o_stat[5].timer_run_status)
        else $error("repeat cycle did not stop");
    a_elapsed_range: assert property (o_stat[0].timer_run_status |->
        o_stat[0].elapsed_time_value < o_cfg[0].first_delay_time)
        else $error("elapsed count beyond the delay");

    c_single_on: cover property ($rose(o_stat[4].switch_state));
    c_repeat_off: cover property ($fell(o_stat[5].switch_state) && i_timer_input[5]);
    c_retrig: cover property ($changed(i_timer_input[3]) && o_stat[3].timer_run_status);
endmodule // mmdt_timer_bank_sva

bind mmdt_timer_bank mmdt_timer_bank_sva #(.TICK_PERIOD(TICK_PERIOD)) mmdt_timer_bank_sva_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_we(i_cfg_we), .i_cfg(i_cfg),
    .i_timer_input(i_timer_input), .o_cfg(o_cfg), .o_stat(o_stat));

// ---- mmdt_timer_bank_tb.sv ----
// Self-checking bench for the timer bank, one mode on each channel.
// Assumes a 4-cycle tick, so a tenth of a second lasts 4 clocks.
`timescale 1ns/1ps
module mmdt_timer_bank_tb;
    import mmdt_pkg::*;
    localparam logic [23:0] TP = 24'h000004;
    localparam logic signed [15:0] ON_V = 16'sh1388;
    localparam logic signed [15:0] OFF_V = -16'sh0bb8;
    localparam mmdt_mode_t MD [NUM_TIMERS] = '{MMDT_ON_DELAY, MMDT_OFF_DELAY, MMDT_ONE_SHOT,
        MMDT_ONE_SHOT_RETRIG, MMDT_SINGLE_CYCLE, MMDT_REPEAT_CYCLE};
    localparam logic [12:0] D1 [NUM_TIMERS] = '{13'h2, 13'h1, 13'h3, 13'h3, 13'h2, 13'h2};
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [5:0] we;
    logic [5:0] tin;
    mmdt_cfg_t ci [NUM_TIMERS];
    mmdt_cfg_t co [NUM_TIMERS];
    mmdt_stat_t so [NUM_TIMERS];
    int err_count = 0;
    int checks = 0;

    always #5 i_clk = ~i_clk;

    mmdt_link_src mmdt_link_src_i (.i_clk(i_clk), .o_cfg_we(we), .o_cfg(ci), .o_timer_input(tin));
    mmdt_timer_bank #(.TICK_PERIOD(TP)) mmdt_timer_bank_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_cfg_we(we), .i_cfg(ci), .i_timer_input(tin), .o_cfg(co), .o_stat(so));

    task automatic stop_test();
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Run status, switch and result packed into one word
    function automatic logic [31:0] ex(input logic r, input logic s);
        return {14'h0000, r, s, s ? ON_V : OFF_V};
    endfunction

    task automatic look(input int ch, input logic r, input logic s);
        chk({so[ch].timer_run_status, so[ch].switch_state, so[ch].timer_result}, ex(r, s));
    endtask

    task automatic drive(input int ch, input logic v);
        mmdt_link_src_i.set_in(ch, v);
        @(negedge i_clk);
    endtask

    // Tick phase is free running, so only a window of cycles can be expected
    task automatic wait_sw(input int ch, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (so[ch].switch_state !== v && n < hi) begin
            @(negedge i_clk);
            n++;
        end
        checks++;
        if (n < lo || n >= hi) begin
            err_count++;
            $display("unexpected at %0t: waited %h, expected %h", $time, n, lo);
            stop_test();
        end
    endtask

    initial begin
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        @(negedge i_clk);
        for (int g = 0; g < NUM_TIMERS; g++) begin
            chk(co[g], {MODE_RST, DLY1_RST, DLY2_RST, ON_VAL_RST, OFF_VAL_RST});
            chk({so[g].timer_run_status, so[g].switch_state, so[g].timer_result}, 0);
            mmdt_link_src_i.load(g, '{MD[g], D1[g], 13'h0003, ON_V, OFF_V});
            look(g, 1'b0, 1'b0);
        end
        drive(0, 1'b1);
        look(0, 1'b1, 1'b0);
        chk(so[0].elapsed_time_value, 0);
        wait_sw(0, 1'b1, 3, 12);
        look(0, 1'b0, 1'b1);
        drive(0, 1'b0);
        look(0, 1'b0, 1'b0);
        drive(1, 1'b1);
        look(1, 1'b0, 1'b1);
        drive(1, 1'b0);
        look(1, 1'b1, 1'b1);
        wait_sw(1, 1'b0, 0, 7);
        drive(2, 1'b1);
        look(2, 1'b1, 1'b1);
        repeat (3) @(negedge i_clk);
        drive(2, 1'b0);
        drive(2, 1'b1);
        look(2, 1'b1, 1'b1);
        wait_sw(2, 1'b0, 0, 8);
        repeat (8) @(negedge i_clk);
        look(2, 1'b0, 1'b0);
        drive(2, 1'b0);
        drive(2, 1'b1);
        look(2, 1'b1, 1'b1);
        drive(3, 1'b1);
        repeat (4) @(negedge i_clk);
        drive(3, 1'b0);
        look(3, 1'b1, 1'b1);
        chk(so[3].elapsed_time_value, 0);
        wait_sw(3, 1'b0, 7, 16);
        drive(4, 1'b1);
        look(4, 1'b1, 1'b0);
        wait_sw(4, 1'b1, 3, 12);
        look(4, 1'b1, 1'b1);
        wait_sw(4, 1'b0, 10, 15);
        look(4, 1'b0, 1'b0);
        drive(5, 1'b1);
        look(5, 1'b1, 1'b1);
        wait_sw(5, 1'b0, 3, 12);
        wait_sw(5, 1'b1, 10, 15);
        drive(5, 1'b0);
        look(5, 1'b0, 1'b0);
        repeat (12) @(negedge i_clk);
        look(5, 1'b0, 1'b0);
        mmdt_link_src_i.load(0, '{mmdt_mode_t'(3'h6), 13'h1fff, 13'h0000, 16'sh7fff,
            -16'sh8000});
        chk(co[0], {MMDT_ON_DELAY, DLY_MAX, DLY_MIN, VAL_MAX, VAL_MIN});
        chk(so[0].timer_result, VAL_MIN);
        stop_test();
    end
endmodule // mmdt_timer_bank_tb
